// [verilog/ces_carriage_sensor.sv]
`timescale 1ns/100ps
// What this block does
// - split each measured encoder cycle into three, strobing at 360dpi.
// - direction comes from which channel leads, reported continuously.
// - direction goes to the print path for bidirectional correction.
// - home flagged while home beam is blocked.
// - capping reached flagged when beam blocked during purge at capping position.
// - lever contact closed means fanfold, open means cut sheet.
// - paper present while paper-end sensor is pressed.
// - width sensor classifies sheet wider or narrower than A4 landscape.
module ces_carriage_sensor #(
    parameter int DEB_CYC = ces_pkg::DEBOUNCE_CYC,
    parameter int PERIOD_W = ces_pkg::PERIOD_W
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // encoder pins
    input wire logic encoder_channel_a_in,
    input wire logic encoder_channel_b_in,
    // sensor pins, high = active
    input wire logic home_blocked_in,
    input wire logic lever_closed_in,
    input wire logic paper_end_sensor_in,
    input wire logic width_sensor_in,
    // controller says carriage parked at cap and purge unit running
    input wire logic purge_active_in,
    // results
    output ces_pkg::ces_status_t status_out,
    output ces_pkg::ces_print_t print_out,
    output ces_pkg::ces_dir_t dir_out
);
    logic [ces_pkg::SENS_N-1:0] raw;
    logic [ces_pkg::SENS_N-1:0] clean;

    assign raw[ces_pkg::IDX_ENC_A] = encoder_channel_a_in;
    assign raw[ces_pkg::IDX_ENC_B] = encoder_channel_b_in;
    assign raw[ces_pkg::IDX_HOME] = home_blocked_in;
    assign raw[ces_pkg::IDX_LEVER] = lever_closed_in;
    assign raw[ces_pkg::IDX_PAPER_END] = paper_end_sensor_in;
    assign raw[ces_pkg::IDX_WIDTH] = width_sensor_in;

    genvar gi;
    generate
        for (gi = 0; gi < ces_pkg::SENS_N; gi++) begin : g_in
            ces_sync #(.DEB_CYC(DEB_CYC)) u_sync (
                .clk_in(clk_in),
                .nrst_in(nrst_in),
                .raw_in(raw[gi]),
                .clean_out(clean[gi])
            );
        end
    endgenerate

    logic enc_a;
    logic enc_b;
    assign enc_a = clean[ces_pkg::IDX_ENC_A];
    assign enc_b = clean[ces_pkg::IDX_ENC_B];

    // decoder and interpolator state
    logic prev_a;
    logic prev_b;
    ces_pkg::ces_dir_t dir;
    logic err;
    ces_pkg::ces_state_t state;
    logic [PERIOD_W-1:0] period;
    logic [PERIOD_W-1:0] elapsed;
    logic [PERIOD_W-1:0] phase_cnt;
    logic [1:0] strobes_left;
    logic strobe;
    logic next_prev_a;
    logic next_prev_b;
    ces_pkg::ces_dir_t next_dir;
    logic next_err;
    ces_pkg::ces_state_t next_state;
    logic [PERIOD_W-1:0] next_period;
    logic [PERIOD_W-1:0] next_elapsed;
    logic [PERIOD_W-1:0] next_phase_cnt;
    logic [1:0] next_strobes_left;
    logic next_strobe;
    logic chg_a;
    logic chg_b;
    logic cycle_edge;
    logic [PERIOD_W-1:0] third;

    assign chg_a = enc_a ^ prev_a;
    assign chg_b = enc_b ^ prev_b;
    // rising A edge marks one full 120dpi cycle
    assign cycle_edge = chg_a && enc_a && !chg_b;
    // last full period drives this cycle's spacing; lags a speed change by one cycle
    assign third = period / PERIOD_W'(ces_pkg::INTERP_DIV);

    always_comb begin
        next_prev_a = enc_a;
        next_prev_b = enc_b;
        next_dir = dir;
        next_err = 1'b0;
        if (chg_a && chg_b) begin
            next_err = 1'b1;
        end else if (chg_a) begin
            // A moved: A leads when A now differs from B
            next_dir = (enc_a != enc_b) ? ces_pkg::CES_DIR_FWD : ces_pkg::CES_DIR_REV;
        end else if (chg_b) begin
            next_dir = (enc_a == enc_b) ? ces_pkg::CES_DIR_FWD : ces_pkg::CES_DIR_REV;
        end
    end

    always_comb begin
        next_state = state;
        next_period = period;
        next_elapsed = elapsed;
        next_phase_cnt = phase_cnt;
        next_strobes_left = strobes_left;
        next_strobe = 1'b0;
        if (elapsed != '1) begin
            next_elapsed = elapsed + 1'b1;
        end
        case (state)
            ces_pkg::CES_ST_IDLE: begin
                if (cycle_edge) begin
                    next_elapsed = '0;
                    next_state = ces_pkg::CES_ST_MEASURE;
                end
            end
            ces_pkg::CES_ST_MEASURE: begin
                if (cycle_edge) begin
                    next_period = elapsed + 1'b1;
                    next_elapsed = '0;
                    next_state = ces_pkg::CES_ST_RUN;
                    next_strobe = 1'b1;
                    next_phase_cnt = '0;
                    next_strobes_left = 2'(ces_pkg::INTERP_DIV - 1);
                end
            end
            ces_pkg::CES_ST_RUN: begin
                if (elapsed == '1) begin
                    // carriage stopped: wait for a fresh period
                    next_state = ces_pkg::CES_ST_IDLE;
                    next_strobes_left = '0;
                end else if (cycle_edge) begin
                    next_period = elapsed + 1'b1;
                    next_elapsed = '0;
                    next_strobe = 1'b1;
                    next_phase_cnt = '0;
                    next_strobes_left = 2'(ces_pkg::INTERP_DIV - 1);
                end else if (strobes_left != '0) begin
                    if (phase_cnt + 1'b1 >= third) begin
                        next_strobe = 1'b1;
                        next_phase_cnt = '0;
                        next_strobes_left = strobes_left - 1'b1;
                    end else begin
                        next_phase_cnt = phase_cnt + 1'b1;
                    end
                end
            end
            default: begin
                next_state = ces_pkg::CES_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            prev_a <= 1'b0;
            prev_b <= 1'b0;
            dir <= ces_pkg::CES_DIR_FWD;
            err <= 1'b0;
            state <= ces_pkg::CES_ST_IDLE;
            period <= '0;
            elapsed <= '0;
            phase_cnt <= '0;
            strobes_left <= '0;
            strobe <= 1'b0;
        end else begin
            prev_a <= next_prev_a;
            prev_b <= next_prev_b;
            dir <= next_dir;
            err <= next_err;
            state <= next_state;
            period <= next_period;
            elapsed <= next_elapsed;
            phase_cnt <= next_phase_cnt;
            strobes_left <= next_strobes_left;
            strobe <= next_strobe;
        end
    end

    // sensor results registered for clean outputs
    ces_pkg::ces_status_t status;
    ces_pkg::ces_status_t next_status;

    always_comb begin
        next_status.home = clean[ces_pkg::IDX_HOME];
        next_status.capping = clean[ces_pkg::IDX_HOME] && purge_active_in;
        next_status.fanfold = clean[ces_pkg::IDX_LEVER];
        next_status.paper_present = clean[ces_pkg::IDX_PAPER_END];
        // sensor pressed means paper reaches past the width point
        next_status.wide_sheet = clean[ces_pkg::IDX_WIDTH];
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            status <= '0;
        end else begin
            status <= next_status;
        end
    end

    assign status_out = status;
    assign print_out = '{reverse: (dir == ces_pkg::CES_DIR_REV), strobe: strobe,
        enc_error: err};
    assign dir_out = dir;
endmodule

// [include/ces_pkg.sv]
package ces_pkg;
    // three flip-flops per pin, change accepted once the last two agree for the debounce count
    localparam int SYNC_STAGES = 3;
    // debounce: input must hold steady this long before it is accepted
    localparam int DEBOUNCE_NS = 1000;
    localparam int CLK_PERIOD_NS = 4;
    localparam int DEBOUNCE_CYC = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEB_W = 9;
    // interpolation: strobes per encoder cycle
    localparam int INTERP_DIV = 3;
    localparam int PERIOD_W = 24;
    // sensor vector positions
    localparam int SENS_N = 6;
    localparam int IDX_ENC_A = 0;
    localparam int IDX_ENC_B = 1;
    localparam int IDX_HOME = 2;
    localparam int IDX_LEVER = 3;
    localparam int IDX_PAPER_END = 4;
    localparam int IDX_WIDTH = 5;
    // width sensor sits this many characters at this pitch from left edge
    localparam int WIDTH_SENSOR_CHARS = 114;
    localparam int WIDTH_SENSOR_CPI = 10;

    typedef enum logic [1:0] {
        CES_DIR_FWD = 2'h1,
        CES_DIR_REV = 2'h2
    } ces_dir_t;

    typedef enum logic [2:0] {
        CES_ST_IDLE = 3'h1,
        CES_ST_MEASURE = 3'h2,
        CES_ST_RUN = 3'h4
    } ces_state_t;

    typedef struct packed {
        logic home;
        logic capping;
        logic fanfold;
        logic paper_present;
        logic wide_sheet;
    } ces_status_t;

    typedef struct packed {
        logic reverse;
        logic strobe;
        logic enc_error;
    } ces_print_t;
endpackage

// [verilog/ces_sync.sv]
`timescale 1ns/100ps
module ces_sync #(
    parameter int DEB_CYC = ces_pkg::DEBOUNCE_CYC
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // raw pin and clean level
    input wire logic raw_in,
    output logic clean_out
);
    logic [ces_pkg::SYNC_STAGES-1:0] stage;
    logic [ces_pkg::DEB_W-1:0] cnt;
    logic clean;
    logic [ces_pkg::SYNC_STAGES-1:0] next_stage;
    logic [ces_pkg::DEB_W-1:0] next_cnt;
    logic next_clean;

    // stage[0] is only read by stage[1]; compare uses stages 1 and 2
    always_comb begin
        next_stage = {stage[ces_pkg::SYNC_STAGES-2:0], raw_in};
        next_cnt = cnt;
        next_clean = clean;
        if (stage[ces_pkg::SYNC_STAGES-2] != stage[ces_pkg::SYNC_STAGES-1]
                || stage[ces_pkg::SYNC_STAGES-1] == clean) begin
            next_cnt = '0;
        end else if (cnt >= ces_pkg::DEB_W'(DEB_CYC - 1)) begin
            next_clean = stage[ces_pkg::SYNC_STAGES-1];
            next_cnt = '0;
        end else begin
            next_cnt = cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            stage <= '0;
            cnt <= '0;
            clean <= 1'b0;
        end else begin
            stage <= next_stage;
            cnt <= next_cnt;
            clean <= next_clean;
        end
    end

    assign clean_out = clean;
endmodule

// [tb/ces_carriage_sensor_sva.sv]
`timescale 1ns/100ps
module ces_carriage_sensor_chk (
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // sensor pins
    input wire logic home_blocked_in,
    input wire logic lever_closed_in,
    input wire logic paper_end_sensor_in,
    input wire logic width_sensor_in,
    input wire logic purge_active_in,
    // results
    input wire ces_pkg::ces_status_t status_out,
    input wire ces_pkg::ces_print_t print_out,
    input wire ces_pkg::ces_dir_t dir_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    // depth 5: three sync stages, the accept cycle and the status register
    property p_home;
        $changed(status_out.home) |-> status_out.home == $past(home_blocked_in, 5);
    endproperty
    a_home: assert property (p_home) else $error("home flag moved without pin");
    property p_fan;
        $changed(status_out.fanfold) |-> status_out.fanfold == $past(lever_closed_in, 5);
    endproperty
    a_fan: assert property (p_fan) else $error("fanfold flag moved without pin");
    property p_pap;
        $changed(status_out.paper_present) |->
            status_out.paper_present == $past(paper_end_sensor_in, 5);
    endproperty
    a_pap: assert property (p_pap) else $error("paper flag moved without pin");
    property p_wide;
        $changed(status_out.wide_sheet) |-> status_out.wide_sheet == $past(width_sensor_in, 5);
    endproperty
    a_wide: assert property (p_wide) else $error("width flag moved without pin");
    property p_cap; status_out.capping == (status_out.home && $past(purge_active_in)); endproperty
    a_cap: assert property (p_cap) else $error("capping flag wrong");
    property p_rev; print_out.reverse == (dir_out == ces_pkg::CES_DIR_REV); endproperty
    a_rev: assert property (p_rev) else $error("reverse flag disagrees with direction");
    property p_dir; dir_out inside {ces_pkg::CES_DIR_FWD, ces_pkg::CES_DIR_REV}; endproperty
    a_dir: assert property (p_dir) else $error("direction code illegal");
    property p_err; print_out.enc_error |-> $stable(dir_out); endproperty
    a_err: assert property (p_err) else $error("direction moved on encoder error");
endmodule
bind ces_carriage_sensor ces_carriage_sensor_chk chk (.clk_in, .nrst_in, .home_blocked_in,
    .lever_closed_in, .paper_end_sensor_in, .width_sensor_in, .purge_active_in, .status_out,
    .print_out, .dir_out);

// [tb/ces_enc_model.sv]
`timescale 1ns/100ps
module ces_enc_model (
    // clock
    input wire logic clk_in,
    // encoder channels
    output logic enc_a_out,
    output logic enc_b_out
);
    initial begin
        enc_a_out = 1'b0;
        enc_b_out = 1'b0;
    end
    // whole cycles only, so the pair always ends back at the levels it started from
    // rev low: channel a leads; rev high: channel b leads
    task automatic move(input int n, input bit rev, input int q);
        for (int i = 0; i < 4 * n; i++) begin
            repeat (q) @(posedge clk_in);
            if ((i % 2 == 0) != rev) enc_a_out <= ~enc_a_out;
            else enc_b_out <= ~enc_b_out;
        end
    endtask
    // faulty pattern: both channels flip on one edge
    task automatic both;
        repeat (12) @(posedge clk_in);
        enc_a_out <= ~enc_a_out;
        enc_b_out <= ~enc_b_out;
    endtask
endmodule

// [tb/ces_carriage_sensor_bench.sv]
`timescale 1ns/100ps
module ces_carriage_sensor_bench;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic home_in = 1'b0, lever_in = 1'b0, pe_in = 1'b0, width_in = 1'b0, purge_in = 1'b0;
    logic enc_a, enc_b;
    ces_pkg::ces_status_t status_out;
    ces_pkg::ces_print_t print_out;
    ces_pkg::ces_dir_t dir_out;
    int errors = 0, tests_run = 0, strobes = 0, fails = 0, cyc = 0, t0 = 0, t1 = 0;
    logic [4:0] pats [7] = '{5'h10, 5'h11, 5'h01, 5'h08, 5'h04, 5'h02, 5'h00};
    initial forever #2 clk_in = ~clk_in;
    ces_enc_model model (.clk_in(clk_in), .enc_a_out(enc_a), .enc_b_out(enc_b));
    ces_carriage_sensor #(.DEB_CYC(4)) dut (.clk_in(clk_in), .nrst_in(nrst_in),
        .encoder_channel_a_in(enc_a), .encoder_channel_b_in(enc_b), .home_blocked_in(home_in),
        .lever_closed_in(lever_in), .paper_end_sensor_in(pe_in), .width_sensor_in(width_in),
        .purge_active_in(purge_in), .status_out(status_out), .print_out(print_out),
        .dir_out(dir_out));
    always @(posedge clk_in) begin
        cyc++;
        if (print_out.strobe === 1'b1) begin
            if (strobes == 0) t0 = cyc;
            if (strobes == 1) t1 = cyc;
            strobes++;
        end
        if (print_out.enc_error === 1'b1) fails++;
    end
    task conclude;
        if (errors == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s exp %h got %h", name, exp, got);
        end
    endtask
    task t_reset;
        @(posedge clk_in);
        nrst_in <= 1'b0;
        repeat (12) @(posedge clk_in);
        chk("rst status", 32'h0, status_out);
        chk("rst dir", ces_pkg::CES_DIR_FWD, dir_out);
        nrst_in <= 1'b1;
        @(posedge clk_in);
        chk("rst print", 32'h0, print_out);
    endtask
    task t_sens;
        foreach (pats[i]) begin
            {home_in, lever_in, pe_in, width_in, purge_in} <= pats[i];
            repeat (20) @(posedge clk_in);
            chk("status", {pats[i][4], pats[i][4] & pats[i][0], pats[i][3:1]},
                status_out);
        end
        home_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        home_in <= 1'b0;
        repeat (20) @(posedge clk_in);
        chk("glitch home", 32'h0, status_out.home);
    endtask
    // reverse first: reset leaves forward, so each check must see a real change
    task t_dir;
        model.move(2, 1'b1, 8);
        repeat (20) @(posedge clk_in);
        chk("dir rev", {ces_pkg::CES_DIR_REV, 1'b1}, {dir_out, print_out.reverse});
        model.move(2, 1'b0, 8);
        repeat (20) @(posedge clk_in);
        chk("dir fwd", {ces_pkg::CES_DIR_FWD, 1'b0}, {dir_out, print_out.reverse});
    endtask
    task t_strobe;
        t_reset();
        strobes = 0;
        model.move(6, 1'b0, 12);
        repeat (60) @(posedge clk_in);
        // first rise only measures; five later rises give three each
        chk("strobe count", 32'd15, strobes);
        chk("strobe gap", 32'd16, t1 - t0);
    endtask
    task t_err;
        fails = 0;
        model.both();
        model.both();
        repeat (20) @(posedge clk_in);
        chk("enc errors", 32'd2, fails);
        chk("dir held", ces_pkg::CES_DIR_FWD, dir_out);
    endtask
    initial begin
        t_reset();
        t_sens();
        t_dir();
        t_strobe();
        t_err();
        conclude();
    end
    initial begin
        #20000;
        errors++;
        conclude();
    end
endmodule
